// ==== ulps_regs.svh ====
// Constants for the ULPI PHY link-side signalling block
`ifndef ULPS_REGS_SVH
`define ULPS_REGS_SVH

`define ULPS_DATA_W        8
`define ULPS_DATA_MSB      7
`define ULPS_DATA_LSB      0
`define ULPS_RESET_MIN_NS  1000
`define ULPS_CLK_PERIOD_PS 8000
`define ULPS_RESET_MIN_CYC \
  ((`ULPS_RESET_MIN_NS * 1000 + `ULPS_CLK_PERIOD_PS - 1) / `ULPS_CLK_PERIOD_PS)
`define ULPS_RCNT_W        8
`define ULPS_IDLE_BYTE     8'h00

`endif

// ==== ulps_pkg.sv ====
// Types shared by the ULPI PHY link-side signalling block
package ulps_pkg;

  // Link-side sequencer states
  typedef enum logic [2:0]
  {
    ULPS_IDLE    = 3'b000,
    ULPS_LTX     = 3'b001,
    ULPS_LEND    = 3'b010,
    ULPS_TURN_UP = 3'b011,
    ULPS_DTX     = 3'b100,
    ULPS_TURN_DN = 3'b101
  } ulps_state_t;

endpackage

// ==== ulps_phy_link.sv ====
// ULPI PHY link-side signalling: bus ownership, throttle, stop, reset, strap
`timescale 1ns/1ps
`include "ulps_regs.svh"

module ulps_phy_link
  import ulps_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic                   LINK_CLK,
  input  wire logic                   CHIP_RESET_LOW,
  input  wire logic                   INTERFACE_CLOCK_OUTPUT_I,
  output logic                        INTERFACE_CLOCK_OUTPUT_OE,
  output logic                        CLOCK_INPUT_MODE,
  output logic                        AUDIO_SWITCH_CLOSED,
  input  wire logic [`ULPS_DATA_MSB:0] DATA_I,
  output logic [`ULPS_DATA_MSB:0]      DATA_O,
  output logic                        DATA_OE,
  output logic                        DIR_O,
  output logic                        DIR_OE,
  output logic                        NXT_O,
  output logic                        NXT_OE,
  input  wire logic                   STP_I,
  input  wire logic                   TX_VALID,
  input  wire logic [`ULPS_DATA_MSB:0] TX_DATA,
  output logic                        TX_READY,
  output logic                        RX_VALID,
  output logic [`ULPS_DATA_MSB:0]      RX_DATA,
  output logic                        RX_LAST,
  input  wire logic                   RX_READY
);

  // ****************************************************************
  // System clock domain: reset, strap, audio switch
  // ****************************************************************

  logic                     crst_meta_reg;
  logic                     crst_reg;
  logic                     strap_meta_reg;
  logic                     strap_reg;
  logic [`ULPS_RCNT_W-1:0]  rcnt_reg;
  logic                     armed_reg;
  logic                     srst_lvl_reg;
  logic [3:0]               srst_hold_reg;
  logic                     srst;
  logic                     rcnt_full;

  localparam logic [`ULPS_RCNT_W-1:0] RCNT_MIN =
    `ULPS_RCNT_W'(`ULPS_RESET_MIN_CYC);

  // Chip reset pin is asynchronous to every clock
  always_ff @(posedge CLK)
  begin
    crst_meta_reg <= ~CHIP_RESET_LOW;
    crst_reg      <= crst_meta_reg;
  end

  // Strap level is a pin; caught only after two flops
  always_ff @(posedge CLK)
  begin
    strap_meta_reg <= INTERFACE_CLOCK_OUTPUT_I;
    strap_reg      <= strap_meta_reg;
  end

  assign srst      = RST | crst_reg;
  assign rcnt_full = (rcnt_reg == RCNT_MIN);

  // Measures the low time; short pulses do not re-arm the strap
  always_ff @(posedge CLK)
  begin
    if (RST || !crst_reg)
      rcnt_reg <= '0;
    else if (!rcnt_full)
      rcnt_reg <= rcnt_reg + `ULPS_RCNT_W'(1);
  end

  // Strap sampled on release of a qualified reset
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      armed_reg        <= 1'b1;
      CLOCK_INPUT_MODE <= 1'b0;
    end
    else if (crst_reg && rcnt_full)
      armed_reg <= 1'b1;
    else if (!crst_reg && armed_reg)
    begin
      armed_reg        <= 1'b0;
      CLOCK_INPUT_MODE <= strap_reg;
    end
  end

  // Clock pad drives only in clock-output mode and out of reset
  always_ff @(posedge CLK)
  begin
    INTERFACE_CLOCK_OUTPUT_OE <= ~srst & ~armed_reg
                                 & ~CLOCK_INPUT_MODE;
    AUDIO_SWITCH_CLOSED       <= crst_reg;
    srst_hold_reg             <= {srst_hold_reg[2:0], srst};
    srst_lvl_reg              <= srst | (|srst_hold_reg); // Outlasts LINK_CLK
  end

  // ****************************************************************
  // System clock domain: transmit and receive handshakes
  // ****************************************************************

  logic                     tx_req_reg;
  logic [`ULPS_DATA_MSB:0]  tx_hold_reg;
  logic                     tx_ack_meta_reg;
  logic                     tx_ack_s_reg;
  logic                     rx_ack_reg;
  logic                     rx_req_meta_reg;
  logic                     rx_req_s_reg;
  logic                     tx_take;
  logic                     tx_idle;
  logic                     rx_pend;
  logic                     rx_take;
  logic                     tx_ack_l_reg;
  logic                     rx_req_l_reg;
  logic [`ULPS_DATA_MSB:0]  rx_byte_reg;
  logic                     rx_last_reg;

  // Toggle returns from the link domain
  always_ff @(posedge CLK)
  begin
    tx_ack_meta_reg <= tx_ack_l_reg;
    tx_ack_s_reg    <= tx_ack_meta_reg;
    rx_req_meta_reg <= rx_req_l_reg;
    rx_req_s_reg    <= rx_req_meta_reg;
  end

  assign tx_idle = (tx_req_reg == tx_ack_s_reg);
  assign tx_take = TX_VALID & TX_READY;
  assign rx_pend = (rx_req_s_reg != rx_ack_reg);
  assign rx_take = RX_VALID & RX_READY;

  // One byte in flight each way; ready falls until the link answers
  always_ff @(posedge CLK)
  begin
    if (srst)
    begin
      tx_req_reg <= 1'b0;
      TX_READY   <= 1'b0;
      rx_ack_reg <= 1'b0;
      RX_VALID   <= 1'b0;
    end
    else
    begin
      tx_req_reg <= tx_req_reg ^ tx_take;
      TX_READY   <= tx_idle & ~tx_take;
      rx_ack_reg <= rx_ack_reg ^ rx_take;
      RX_VALID   <= rx_pend & ~rx_take;
    end
  end

  // Held data is stable while its toggle is outstanding
  always_ff @(posedge CLK)
  begin
    if (tx_take)
      tx_hold_reg <= TX_DATA;
    if (rx_pend)
    begin
      RX_DATA <= rx_byte_reg;
      RX_LAST <= rx_last_reg;
    end
  end

  // ****************************************************************
  // Link clock domain: synchronisers
  // ****************************************************************

  logic lrst_meta_reg;
  logic lrst_reg;
  logic tx_req_meta_reg;
  logic tx_req_l_reg;
  logic rx_ack_meta_reg;
  logic rx_ack_l_reg;

  // Reset and toggles enter the interface clock domain
  always_ff @(posedge LINK_CLK)
  begin
    lrst_meta_reg   <= srst_lvl_reg;
    lrst_reg        <= lrst_meta_reg;
    tx_req_meta_reg <= tx_req_reg;
    tx_req_l_reg    <= tx_req_meta_reg;
    rx_ack_meta_reg <= rx_ack_reg;
    rx_ack_l_reg    <= rx_ack_meta_reg;
  end

  // ****************************************************************
  // Link clock domain: bus sequencer
  // ****************************************************************

  ulps_state_t              st_reg;
  ulps_state_t              st_next;
  logic [`ULPS_DATA_MSB:0]  pend_reg;
  logic                     pend_v_reg;
  logic                     pend_v_next;
  logic                     dir_next;
  logic                     nxt_next;
  logic                     oe_next;
  logic                     push;
  logic                     push_last;
  logic                     tx_pend;
  logic                     slot_free;
  logic                     capture;
  logic                     cmd_seen;

  assign tx_pend   = (tx_req_l_reg != tx_ack_l_reg);
  assign slot_free = (rx_req_l_reg == rx_ack_l_reg);
  assign cmd_seen  = (DATA_I != `ULPS_IDLE_BYTE);
  // Byte on the bus is taken in the cycle next is high
  assign capture   = (st_reg == ULPS_LTX) & NXT_O & ~STP_I;

  // Next state and pin values
  always_comb
  begin
    st_next     = st_reg;
    dir_next    = 1'b0;
    nxt_next    = 1'b0;
    oe_next     = 1'b0;
    pend_v_next = pend_v_reg | capture;
    push        = 1'b0;
    push_last   = 1'b0;
    case (st_reg)
      ULPS_IDLE:
      begin
        if (tx_pend)
        begin
          dir_next = 1'b1;
          st_next  = ULPS_TURN_UP;
        end
        else if (cmd_seen)
        begin
          nxt_next = slot_free;
          st_next  = ULPS_LTX;
        end
      end
      ULPS_LTX:
      begin
        // Previous byte goes out once its follower proves it is not last
        push     = capture & pend_v_reg;
        nxt_next = ~STP_I & slot_free & ~push;
        if (STP_I)
        begin
          if (pend_v_reg && slot_free)
          begin
            push        = 1'b1;
            push_last   = 1'b1;
            pend_v_next = 1'b0;
            st_next     = ULPS_IDLE;
          end
          else if (pend_v_reg)
            st_next = ULPS_LEND;
          else
            st_next = ULPS_IDLE;
        end
      end
      ULPS_LEND:
      begin
        if (slot_free)
        begin
          push        = 1'b1;
          push_last   = 1'b1;
          pend_v_next = 1'b0;
          st_next     = ULPS_IDLE;
        end
      end
      ULPS_TURN_UP:
      begin
        // Turnaround cycle: link releases the bus, nobody drives
        dir_next = 1'b1;
        oe_next  = 1'b1;
        st_next  = ULPS_DTX;
      end
      ULPS_DTX:
        st_next = ULPS_TURN_DN;
      ULPS_TURN_DN:
        st_next = ULPS_IDLE;
      default:
        st_next = ULPS_IDLE;
    endcase
  end

  // Every interface output launches on the rising interface edge
  always_ff @(posedge LINK_CLK)
  begin
    if (lrst_reg)
    begin
      st_reg     <= ULPS_IDLE;
      DIR_O      <= 1'b0;
      NXT_O      <= 1'b0;
      DATA_OE    <= 1'b0;
      DIR_OE     <= 1'b0;
      NXT_OE     <= 1'b0;
      pend_v_reg <= 1'b0;
    end
    else
    begin
      st_reg     <= st_next;
      DIR_O      <= dir_next;
      NXT_O      <= nxt_next;
      DATA_OE    <= oe_next;
      DIR_OE     <= 1'b1;
      NXT_OE     <= 1'b1;
      pend_v_reg <= pend_v_next;
    end
  end

  // Handshake toggles and the receive slot
  always_ff @(posedge LINK_CLK)
  begin
    if (lrst_reg)
    begin
      tx_ack_l_reg <= 1'b0;
      rx_req_l_reg <= 1'b0;
    end
    else
    begin
      tx_ack_l_reg <= tx_ack_l_reg ^ (st_reg == ULPS_DTX);
      rx_req_l_reg <= rx_req_l_reg ^ push;
    end
  end

  // Data registers carry no reset; qualifiers guard them
  always_ff @(posedge LINK_CLK)
  begin
    if (capture)
      pend_reg <= DATA_I;
    if (push)
    begin
      rx_byte_reg <= pend_reg;
      rx_last_reg <= push_last;
    end
    if (st_reg == ULPS_TURN_UP)
      DATA_O <= tx_hold_reg;
  end

endmodule

// ==== ulps_phy_link_asserts.sv ====
// Port-level checks for the ULPI PHY link signalling block
`timescale 1ns/1ps

module ulps_phy_link_chk
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       LINK_CLK,
  input wire logic       CHIP_RESET_LOW,
  input wire logic       INTERFACE_CLOCK_OUTPUT_OE,
  input wire logic       CLOCK_INPUT_MODE,
  input wire logic       AUDIO_SWITCH_CLOSED,
  input wire logic       DATA_OE,
  input wire logic       DIR_O,
  input wire logic       DIR_OE,
  input wire logic       NXT_O,
  input wire logic       NXT_OE,
  input wire logic       TX_VALID,
  input wire logic       TX_READY,
  input wire logic       RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic       RX_READY
);
  // ****************
  // Link side
  // ****************
  sequence s_dev_tx;
    DATA_OE ##1 (!DIR_O && !DATA_OE);
  endsequence
  property p_tx_window;
    @(posedge LINK_CLK) disable iff (RST || !CHIP_RESET_LOW)
    $rose(DIR_O) |=> s_dev_tx;
  endproperty
  a_tx_window: assert property (p_tx_window)
    else $error("transmit window malformed");
  // Next belongs to link transmit only, never inside a device window
  property p_nxt_owner;
    @(posedge LINK_CLK) disable iff (RST || !CHIP_RESET_LOW)
    NXT_O |-> !DIR_O && !DATA_OE;
  endproperty
  a_nxt_owner: assert property (p_nxt_owner)
    else $error("next raised while device owns the bus");
  // One-byte slot: command plus one byte, then next must drop
  property p_nxt_throttle;
    @(posedge LINK_CLK) disable iff (RST || !CHIP_RESET_LOW)
    NXT_O ##1 NXT_O |=> !NXT_O;
  endproperty
  a_nxt_throttle: assert property (p_nxt_throttle)
    else $error("next held over two cycles");
  // Sync delay on the pin, hence the run-in
  property p_float;
    @(posedge LINK_CLK) disable iff (RST)
    !CHIP_RESET_LOW [*6] |-> !(DIR_OE || NXT_OE || DATA_OE);
  endproperty
  a_float: assert property (p_float)
    else $error("outputs driven in chip reset");
  // ****************
  // System side
  // ****************
  property p_audio;
    @(posedge CLK) disable iff (RST)
    !CHIP_RESET_LOW [*5] |-> AUDIO_SWITCH_CLOSED;
  endproperty
  a_audio: assert property (p_audio)
    else $error("audio switch open in reset");
  property p_audio_open;
    @(posedge CLK) disable iff (RST)
    CHIP_RESET_LOW [*5] |-> !AUDIO_SWITCH_CLOSED;
  endproperty
  a_audio_open: assert property (p_audio_open)
    else $error("audio switch closed in operation");
  property p_clk_mode;
    @(posedge CLK) disable iff (RST)
    CLOCK_INPUT_MODE |-> !INTERFACE_CLOCK_OUTPUT_OE;
  endproperty
  a_clk_mode: assert property (p_clk_mode)
    else $error("clock pad driven in input mode");
  property p_tx_dir;
    @(posedge CLK) disable iff (RST || !CHIP_RESET_LOW)
    TX_VALID && TX_READY |-> ##[1:30] DIR_O;
  endproperty
  a_tx_dir: assert property (p_tx_dir)
    else $error("direction not raised for transmit");
  property p_rx_hold;
    @(posedge CLK) disable iff (RST || !CHIP_RESET_LOW)
    RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive byte lost while stalled");
endmodule

bind ulps_phy_link ulps_phy_link_chk u_chk
(
  .CLK, .RST, .LINK_CLK, .CHIP_RESET_LOW, .INTERFACE_CLOCK_OUTPUT_OE,
  .CLOCK_INPUT_MODE, .AUDIO_SWITCH_CLOSED, .DATA_OE, .DIR_O, .DIR_OE,
  .NXT_O, .NXT_OE, .TX_VALID, .TX_READY, .RX_VALID, .RX_DATA, .RX_READY
);

// ==== ulps_link_model.sv ====
// Behavioural link controller on the far side of the PHY bus
`timescale 1ns/1ps

module ulps_link_model
(
  input  wire logic       lclk,
  input  wire logic       dir,
  input  wire logic       nxt,
  input  wire logic       doe,
  input  wire logic [7:0] bus,
  output logic [7:0]      ldata,
  output logic            loe,
  output logic            stp
);
  logic [7:0] got [$];

  // Release the bus while the PHY owns it
  assign loe = !dir;

  // Keep every byte the PHY drives, in arrival order
  always @(posedge lclk)
  begin
    if (dir && doe)
      got.push_back(bus);
  end

  initial
  begin
    ldata = 8'h00;
    stp = 1'b0;
  end

  // Advance only on next; one-cycle stop after the last byte
  task automatic send(input logic [7:0] b [$]);
    int i;
    i = 0;
    @(posedge lclk);
    while (dir)
      @(posedge lclk);
    ldata <= b[0];
    while (i < b.size())
    begin
      @(posedge lclk);
      if (nxt)
      begin
        i++;
        ldata <= (i < b.size()) ? b[i] : 8'h00;
      end
    end
    stp <= 1'b1;
    @(posedge lclk);
    stp <= 1'b0;
  endtask
endmodule

// ==== ulps_phy_link_tb_top.sv ====
// Self-checking bench for the ULPI PHY link signalling block
`timescale 1ns/1ps

module ulps_phy_link_tb_top;
  logic       clk, lclk, rst, chip_reset_low, strap;
  logic       tx_valid, rx_ready, stp, loe, clk_oe, clk_in_mode;
  logic       audio, data_oe, dir_o, dir_oe, nxt_o, nxt_oe;
  logic       tx_ready, rx_valid, rx_last;
  logic [7:0] tx_data, rx_data, data_o, ldata, bus;
  logic [7:0] last_bus = 8'h00;
  int         n_mismatch = 0;
  int         num_checks = 0;

  // Released bus shows the inverse of its last level
  assign bus = data_oe ? data_o : (loe ? ldata : ~last_bus);
  always @(posedge lclk)
    last_bus <= bus;

  ulps_phy_link dut
  (
    .CLK(clk), .RST(rst), .LINK_CLK(lclk),
    .CHIP_RESET_LOW(chip_reset_low), .INTERFACE_CLOCK_OUTPUT_I(strap),
    .INTERFACE_CLOCK_OUTPUT_OE(clk_oe), .CLOCK_INPUT_MODE(clk_in_mode),
    .AUDIO_SWITCH_CLOSED(audio), .DATA_I(bus), .DATA_O(data_o),
    .DATA_OE(data_oe), .DIR_O(dir_o), .DIR_OE(dir_oe), .NXT_O(nxt_o),
    .NXT_OE(nxt_oe), .STP_I(stp), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_LAST(rx_last), .RX_READY(rx_ready)
  );

  ulps_link_model lnk
  (
    .lclk(lclk), .dir(dir_oe & dir_o), .nxt(nxt_oe & nxt_o),
    .doe(data_oe), .bus(bus), .ldata(ldata), .loe(loe), .stp(stp)
  );

  // ****************
  // Clocks and checks
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Link clock, offset in phase from the system clock
  initial
  begin
    lclk = 1'b0;
    #3;
    forever #15 lclk = ~lclk;
  end

  task automatic check(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  // Long chip reset with a given strap, then normal running
  task automatic t_chip_reset(input logic s);
    @(posedge clk);
    strap <= s;
    chip_reset_low <= 1'b0;
    repeat (130) @(posedge clk);
    check("float", {nxt_oe, data_oe, dir_oe}, 3'b000);
    check("audio", audio, 1'b1);
    chip_reset_low <= 1'b1;
    repeat (40) @(posedge clk);
    check("audio", audio, 1'b0);
    check("mode", {clk_in_mode, clk_oe}, {s, !s});
    check("idle", {dir_oe, dir_o, tx_ready}, 3'b101);
  endtask

  // Two bytes back to back, valid held between them
  task automatic t_tx;
    logic [7:0] b [2];
    int k;
    b = '{8'h81, 8'h5a};
    lnk.got.delete();
    tx_valid <= 1'b1;
    foreach (b[j])
    begin
      tx_data <= b[j];
      k = 0;
      do
        @(posedge clk);
      while (tx_ready !== 1'b1 && ++k < 200);
    end
    tx_valid <= 1'b0;
    for (k = 0; k < 200 && lnk.got.size() < 2; k++)
      @(posedge clk);
    foreach (b[j])
      check("sent", lnk.got[j], b[j]);
    repeat (20) @(posedge clk);
    check("dir", dir_o, 1'b0);
  endtask

  // Command plus data from the link, consumer stalling
  task automatic t_rx;
    logic [7:0] b [$];
    logic [8:0] seen [$];
    int k;
    b = '{8'h41, 8'h80, 8'h01, 8'h7e};
    fork
      lnk.send(b);
      for (k = 0; k < 900 && seen.size() < 4; k++)
      begin
        @(posedge clk);
        if (rx_valid === 1'b1 && rx_ready)
          seen.push_back({rx_last, rx_data});
        rx_ready <= (k % 3 != 0);
      end
    join
    rx_ready <= 1'b1;
    foreach (b[j])
      check("recv", seen[j], {j == 3, b[j]});
  endtask

  // Single command byte: stop arrives while next is still high
  task automatic t_rx_one;
    logic [7:0] b [$];
    logic [8:0] seen;
    int k;
    b = '{8'hc3};
    seen = 9'h000;
    fork
      lnk.send(b);
      for (k = 0; k < 300 && seen == 9'h000; k++)
      begin
        @(posedge clk);
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
          seen = {rx_last, rx_data};
      end
    join
    check("recv one", seen, {1'b1, b[0]});
  endtask

  // Hang guard, well past the expected run length
  initial
  begin
    #60000;
    n_mismatch++;
    results();
  end

  initial
  begin
    rst = 1'b1;
    chip_reset_low = 1'b1;
    strap = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_chip_reset(1'b1);
    t_chip_reset(1'b0);
    t_tx();
    t_rx();
    t_rx_one();
    t_tx();
    results();
  end
endmodule
